/* File: shared/sync_serial_consts.vh */
/*
 Named constants of the two-wire synchronous serial port: register
 offsets, control and status bit positions, reset values, clock rate
 half periods and transfer counts.
 Assumes an 8-bit register port and one internal bus clock.
*/
`ifndef SYNC_SERIAL_CONSTS_VH
`define SYNC_SERIAL_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_CONTROL    8'h0A
`define ADDR_STATUS     8'h0B
`define ADDR_DATA       8'h0C

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define CTL_IRQ_EN      7
`define CTL_ENABLE      6
`define CTL_LSB_FIRST   5
`define CTL_MASTER      4
`define CTL_IDLE_CLK    3
`define CTL_DATA_DRIVE  2
`define CTL_RATE_HI     1
`define CTL_RATE_LO     0
`define CONTROL_RESET   8'h08

// ----------------------------------------------------------------
// Status register fields and data register reset value
// ----------------------------------------------------------------
`define STS_DONE        7
`define STS_COLLISION   6
`define STS_PIN_SAMPLE  5
`define DATA_RESET      8'h00

// ----------------------------------------------------------------
// Rate select codes and half periods of the master serial clock in bus clocks
// ----------------------------------------------------------------
`define RATE_DIV16      2'h0
`define RATE_DIV8       2'h1
`define RATE_DIV4       2'h2
`define HALF_DIV16      4'h8
`define HALF_DIV8       4'h4
`define HALF_DIV4       4'h2
`define HALF_DIV2       4'h1

// ----------------------------------------------------------------
// Transfer counts
// ----------------------------------------------------------------
`define BITS_LAST       4'h7
`define BITS_ZERO       4'h0
`define BITS_STEP       4'h1
`define TOGGLES_LAST    5'h10
`define TOGGLES_ZERO    5'h00
`define TOGGLES_STEP    5'h01

`endif

/* File: rtl/pin_sync.v */
/*
 Input synchroniser for pins arriving from outside the clock domain.
 Each bit passes three stage flip-flops and an output flip-flop; a new level is accepted only once
 the second and third stages agree.
 Assumes pins change slower than two bus clocks.
*/
module pin_sync #(
    parameter WIDTH = 3
) (
    input  wire             core_clk,
    input  wire             sys_rst,
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] pin_level
);

    reg [WIDTH-1:0] stage_one;
    reg [WIDTH-1:0] stage_two;
    reg [WIDTH-1:0] stage_three;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    stage_one[i]   <= 1'b0;
                    stage_two[i]   <= 1'b0;
                    stage_three[i] <= 1'b0;
                    pin_level[i]   <= 1'b0;
                end else begin
                    stage_one[i]   <= pin_in[i];
                    stage_two[i]   <= stage_one[i];
                    stage_three[i] <= stage_two[i];
                    // Filters a single-cycle glitch
                    if (stage_two[i] == stage_three[i]) begin
                        pin_level[i] <= stage_three[i];
                    end
                end
            end
        end
    endgenerate

endmodule // pin_sync

/* File: rtl/two_wire_sync_serial_port.v */
/*
 Two-wire synchronous serial port: one byte per transfer over a serial
 clock line and one shared data line, as master or slave, with control,
 status and data registers on a plain register port.
 Assumes the CPU strobes are single cycle on core_clk, the pins are
 resolved outside from the output enables, and stop and wait come from
 the clock controller as levels on core_clk.
*/
`include "sync_serial_consts.vh"

module two_wire_sync_serial_port (
    input  wire       core_clk,
    input  wire       sys_rst,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       sck_in,
    output reg        sck_out,
    output reg        sck_oe,
    input  wire       sdio_in,
    output reg        sdio_out,
    output reg        sdio_oe,
    input  wire       port_b_bit_three,
    input  wire [2:0] port_b_ddr,
    output reg  [2:0] port_b_dir,
    input  wire       stop_mode,
    input  wire       wait_mode,
    output reg        irq_req
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg  [7:0] serial_control_reg;
    reg  [7:0] shift_data;
    reg        transfer_done_flag;
    reg        collision_flag;
    reg        pin_sample_bit;
    reg        clear_armed;
    reg        in_window;
    reg  [3:0] bit_count;
    reg        master_run;
    reg  [3:0] half_count;
    reg  [4:0] toggle_count;
    reg        master_sck;
    reg        sck_prev;
    reg        last_in_bit;
    reg        present_due;

    wire [2:0] pin_level;
    wire       sck_level;
    wire       sdio_level;
    wire       pb3_level;

    wire       done_irq_enable       = serial_control_reg[`CTL_IRQ_EN];
    wire       block_enable          = serial_control_reg[`CTL_ENABLE];
    wire       lsb_first             = serial_control_reg[`CTL_LSB_FIRST];
    wire       master_select         = serial_control_reg[`CTL_MASTER];
    wire       idle_clock_level      = serial_control_reg[`CTL_IDLE_CLK];
    wire       data_pin_drive_enable = serial_control_reg[`CTL_DATA_DRIVE];
    wire [1:0] clock_rate_select     = {serial_control_reg[`CTL_RATE_HI],
                                        serial_control_reg[`CTL_RATE_LO]};

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    pin_sync #(
        .WIDTH (3)
    ) pin_sync_i (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .pin_in    ({port_b_bit_three, sdio_in, sck_in}),
        .pin_level (pin_level)
    );

    assign sck_level  = pin_level[0];
    assign sdio_level = pin_level[1];
    assign pb3_level  = pin_level[2];

    // ----------------------------------------------------------------
    // Register access decode
    // ----------------------------------------------------------------
    wire wr_control  = reg_wr & (reg_addr == `ADDR_CONTROL);
    wire rd_status   = reg_rd & (reg_addr == `ADDR_STATUS);
    wire data_access = (reg_wr | reg_rd) & (reg_addr == `ADDR_DATA);
    wire wr_data     = reg_wr & (reg_addr == `ADDR_DATA);

    // ----------------------------------------------------------------
    // Serial clock edges
    // ----------------------------------------------------------------
    // Slave clock from pin
    wire sck_now   = master_select ? master_sck : sck_level;
    wire sck_rise  = block_enable & ~sck_prev & sck_now;
    wire sck_fall  = block_enable & sck_prev & ~sck_now;
    wire done_evt  = sck_rise & (bit_count == `BITS_LAST);
    // Trailing fall of a low-idle byte opens no window
    wire first_fal = sck_fall & ~in_window &
                     ((bit_count != `BITS_ZERO) | idle_clock_level);
    wire busy      = master_run | in_window | (bit_count != `BITS_ZERO);

    reg [3:0] half_period;
    always @* begin
        case (clock_rate_select)
            `RATE_DIV16: half_period = `HALF_DIV16;
            `RATE_DIV8:  half_period = `HALF_DIV8;
            `RATE_DIV4:  half_period = `HALF_DIV4;
            default:     half_period = `HALF_DIV2;
        endcase
    end

    wire master_start = wr_data & ~busy & block_enable & master_select &
                        ~transfer_done_flag & ~sck_rise;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sck_prev <= 1'b0;
        end else begin
            sck_prev <= sck_now;
        end
    end

    // ----------------------------------------------------------------
    // Master clock generator
    // ----------------------------------------------------------------
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            master_run   <= 1'b0;
            half_count   <= `HALF_DIV2;
            toggle_count <= `TOGGLES_ZERO;
            master_sck   <= 1'b1;
        end else if (~block_enable | ~master_select) begin
            master_run   <= 1'b0;
            toggle_count <= `TOGGLES_ZERO;
            master_sck   <= idle_clock_level;
        end else if (master_start) begin
            master_run   <= 1'b1;
            half_count   <= half_period;
            toggle_count <= `TOGGLES_ZERO;
        end else if (master_run & ~stop_mode) begin
            if (half_count == `HALF_DIV2) begin
                half_count   <= half_period;
                master_sck   <= ~master_sck;
                toggle_count <= toggle_count + `TOGGLES_STEP;
                if (toggle_count == `TOGGLES_LAST - `TOGGLES_STEP) begin
                    master_run <= 1'b0;
                end
            end else begin
                half_count <= half_count - `HALF_DIV2;
            end
        end else if (~master_run) begin
            master_sck <= idle_clock_level;
        end
    end

    // ----------------------------------------------------------------
    // Shifter and bit counter
    // ----------------------------------------------------------------
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_data  <= `DATA_RESET;
            bit_count   <= `BITS_ZERO;
            in_window   <= 1'b0;
            last_in_bit <= 1'b0;
            present_due <= 1'b0;
        end else if (~block_enable) begin
            bit_count <= `BITS_ZERO;
            in_window <= 1'b0;
            present_due <= wr_data;
            if (wr_data) begin
                shift_data <= reg_wdata;
            end
        end else begin
            present_due <= 1'b0;
            if (sck_rise) begin
                last_in_bit <= sdio_level;
                if (done_evt) begin
                    bit_count <= `BITS_ZERO;
                    in_window <= 1'b0;
                    // Last bit goes straight in, no trailing fall needed
                    if (lsb_first) begin
                        shift_data <= {sdio_level, shift_data[7:1]};
                    end else begin
                        shift_data <= {shift_data[6:0], sdio_level};
                    end
                end else begin
                    bit_count <= bit_count + `BITS_STEP;
                end
            end else if (sck_fall) begin
                if (first_fal) begin
                    in_window <= 1'b1;
                end
                // Every fall refreshes the pin, the idle-high first bit too
                present_due <= 1'b1;
                if (bit_count != `BITS_ZERO) begin
                    if (lsb_first) begin
                        shift_data <= {last_in_bit, shift_data[7:1]};
                    end else begin
                        shift_data <= {shift_data[6:0], last_in_bit};
                    end
                end
            end else if (wr_data & ~busy) begin
                shift_data  <= reg_wdata;
                present_due <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------
    // Second step of clearing
    wire flag_clear = data_access & clear_armed;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            transfer_done_flag <= 1'b0;
            collision_flag     <= 1'b0;
            pin_sample_bit     <= 1'b0;
            clear_armed        <= 1'b0;
        end else begin
            transfer_done_flag <= done_evt | (transfer_done_flag & ~flag_clear);
            collision_flag <= (data_access & (in_window | first_fal)) |
                              (collision_flag & ~flag_clear);
            if (done_evt) begin
                pin_sample_bit <= pb3_level;
            end
            // Arm on status read with flag set
            if (rd_status) begin
                clear_armed <= transfer_done_flag;
            end else if (data_access) begin
                clear_armed <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control register and read port
    // ----------------------------------------------------------------
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            serial_control_reg <= `CONTROL_RESET;
            reg_rdata          <= `DATA_RESET;
        end else begin
            if (wr_control) begin
                serial_control_reg <= reg_wdata;
            end
            if (reg_rd) begin
                case (reg_addr)
                    `ADDR_CONTROL: reg_rdata <= serial_control_reg;
                    `ADDR_STATUS:  reg_rdata <= {transfer_done_flag, collision_flag,
                                                 pin_sample_bit, 5'h00};
                    `ADDR_DATA:    reg_rdata <= shift_data;
                    default:       reg_rdata <= `DATA_RESET;
                endcase
            end else begin
                reg_rdata <= `DATA_RESET;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pins, direction override and interrupt request
    // ----------------------------------------------------------------
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sck_out    <= 1'b1;
            sck_oe     <= 1'b0;
            sdio_out   <= 1'b0;
            sdio_oe    <= 1'b0;
            port_b_dir <= 3'h0;
            irq_req    <= 1'b0;
        end else begin
            sck_out  <= master_sck;
            // Pin latch holds over the last rise; it moves on falls and after a data write while idle or disabled
            if (present_due) begin
                sdio_out <= lsb_first ? shift_data[0] : shift_data[7];
            end
            sck_oe   <= block_enable & master_select;
            sdio_oe  <= block_enable & data_pin_drive_enable;
            if (block_enable) begin
                port_b_dir <= {master_select, data_pin_drive_enable, 1'b0};
            end else begin
                port_b_dir <= port_b_ddr;
            end
            irq_req <= done_irq_enable & transfer_done_flag &
                       (~stop_mode | wait_mode);
        end
    end

endmodule // two_wire_sync_serial_port

/* File: tb/serial_port_monitor.sv */
/*
 Concurrent checks on the ports of the two-wire serial port.
 Assumes one clock, core_clk, and the asynchronous high reset sys_rst.
*/
`include "sync_serial_consts.vh"
module serial_port_monitor (
    input wire       core_clk,
    input wire       sys_rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       sck_out,
    input wire       sck_oe,
    input wire       sdio_out,
    input wire       sdio_oe,
    input wire       stop_mode,
    input wire       wait_mode,
    input wire [2:0] port_b_dir,
    input wire       irq_req
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------
    // Steps
    // ------------------------------------------------------------
    sequence ctl_wr_rd;
        reg_wr && reg_addr == `ADDR_CONTROL ##1 reg_rd && reg_addr == `ADDR_CONTROL;
    endsequence
    sequence sck_fell_before;
        $past(sck_out, 2) && !$past(sck_out);
    endsequence
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data seen outside its cycle");
    a_unmapped_zero: assert property (reg_rd && (reg_addr < `ADDR_CONTROL ||
        reg_addr > `ADDR_DATA) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_readback: assert property (ctl_wr_rd |=> reg_rdata == $past(reg_wdata, 2))
        else $error("control readback differs");
    a_sdio_on_fall: assert property ($changed(sdio_out) && sck_oe && $past(sck_oe)
        && !$past(reg_wr, 2) |-> sck_fell_before)
        else $error("data pin moved without a falling clock");
    a_stop_sck_hold: assert property (sck_oe && stop_mode && $past(stop_mode)
        && $past(stop_mode, 2) |-> $stable(sck_out))
        else $error("clock moved in stop");
    a_stop_sdio_hold: assert property (sck_oe && stop_mode && $past(stop_mode)
        && $past(stop_mode, 2) |-> $stable(sdio_out))
        else $error("data moved in stop");
    a_irq_stop_quiet: assert property (stop_mode && !wait_mode
        && $past(stop_mode && !wait_mode) |-> !irq_req)
        else $error("request raised while stopped");
    a_clk_dir_override: assert property (sck_oe && $past(sck_oe)
        |-> port_b_dir[2] && !port_b_dir[0])
        else $error("clock pin direction not taken over");
    a_data_dir_override: assert property (sdio_oe && $past(sdio_oe) |-> port_b_dir[1])
        else $error("data pin direction not taken over");
endmodule // serial_port_monitor

/* File: tb/ext_serial_node.sv */
/*
 Far-side serial node: clocks bytes in as link master on request and
 otherwise answers as slave. Assumes MSB first and an idle-low clock.
*/
module ext_serial_node (
    input  wire logic       core_clk,
    input  wire logic       sck_pin,
    input  wire logic       sdio_pin,
    input  wire logic [7:0] tx_byte,
    input  wire logic       load,
    output logic            sck_drv,
    output logic [7:0]      got,
    output logic            sdio_bit
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh;
    logic       prev;
    initial begin
        sck_drv = 1'b0;
        sh = 8'h00;
        prev = 1'b0;
        got = 8'h00;
    end
    assign sdio_bit = sh[7];
    // Sample on rise, present on fall
    // Inverted fill so a stale bit never looks valid
    always @(posedge core_clk) begin
        prev <= sck_pin;
        if (!prev && sck_pin) got <= {got[6:0], sdio_pin};
        if (load) sh <= tx_byte;
        else if (prev && !sck_pin) sh <= {sh[6:0], ~sh[7]};
    end
    // Clock at own rate, idle low
    task automatic drive_byte(input int half);
        for (int i = 0; i < 16; i++) begin
            repeat (half) @(posedge core_clk);
            sck_drv <= ~sck_drv;
        end
    endtask
endmodule // ext_serial_node

/* File: tb/two_wire_sync_serial_port_bench.sv */
/*
 Self-checking bench: register port tasks, a far-side node and scenario
 sequences. Assumes 10 MHz core_clk and the resolved pins built here.
*/
`include "sync_serial_consts.vh"
module two_wire_sync_serial_port_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic       core_clk, sys_rst, reg_wr, reg_rd, port_b_bit_three, stop_mode, wait_mode;
    logic       p_load;
    logic [7:0] reg_addr, reg_wdata, p_tx, d;
    logic [2:0] port_b_ddr;
    wire  [7:0] reg_rdata, p_got;
    wire  [2:0] port_b_dir;
    wire        sck_out, sck_oe, sdio_out, sdio_oe, irq_req, p_sck, p_bit;
    wire        sck_pin = sck_oe ? sck_out : p_sck;
    wire        sdio_pin = sdio_oe ? sdio_out : p_bit;
    int         err_count, check_count, n;
    logic [3:0] half_t [4] = '{`HALF_DIV16, `HALF_DIV8, `HALF_DIV4, `HALF_DIV2};

    two_wire_sync_serial_port two_wire_sync_serial_port_i (
        .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .sck_in(sck_pin), .sck_out, .sck_oe, .sdio_in(sdio_pin), .sdio_out, .sdio_oe,
        .port_b_bit_three, .port_b_ddr, .port_b_dir, .stop_mode, .wait_mode, .irq_req);
    ext_serial_node ext_serial_node_i (
        .core_clk, .sck_pin, .sdio_pin, .tx_byte(p_tx), .load(p_load),
        .sck_drv(p_sck), .got(p_got), .sdio_bit(p_bit));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------
    // Register port and comparison tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        @(posedge core_clk);
        #1 d = reg_rdata;
    endtask
    task automatic cyc(input int k);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (k) @(posedge core_clk);
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(d, e);
    endtask
    // Cycles until the master clock pin changes, capped at lim
    task automatic gap(input int lim);
        logic v;
        cyc(0);
        v = sck_out;
        n = 0;
        while (sck_out === v && n < lim) begin
            @(posedge core_clk);
            #1 n++;
        end
    endtask
    task automatic pload(input logic [7:0] b);
        cyc(0);
        p_tx <= b;
        p_load <= 1'b1;
        @(posedge core_clk);
        p_load <= 1'b0;
    endtask
    task automatic slave_byte(input logic [7:0] b);
        pload(b);
        ext_serial_node_i.drive_byte(8);
        cyc(12);
    endtask
    task conclude;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge core_clk);
        err_count++;
        conclude;
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {sys_rst, reg_wr, reg_rd, port_b_bit_three, stop_mode, wait_mode, p_load} = 7'h40;
        {reg_addr, reg_wdata, p_tx, port_b_ddr} = 27'h0000005;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        cyc(4);
        rdc(`ADDR_CONTROL, `CONTROL_RESET);
        rdc(`ADDR_STATUS, 8'h00);
        wr(`ADDR_STATUS, 8'hFF);
        rdc(`ADDR_STATUS, 8'h00);
        rdc(`ADDR_DATA, `DATA_RESET);
        rdc(8'h0D, 8'h00);
        chk({5'h00, port_b_dir}, 8'h05);
        // Slave mode with a rate set that must not matter
        wr(`ADDR_CONTROL, 8'h43);
        rdc(`ADDR_CONTROL, 8'h43);
        chk({5'h00, port_b_dir}, 8'h00);
        for (int i = 0; i < 3; i++) begin
            port_b_bit_three <= i[0];
            slave_byte(8'hA5 ^ (8'h33 * i[7:0]));
            rdc(`ADDR_STATUS, 8'h80 | {2'h0, i[0], 5'h00});
            if (i != 1) rdc(`ADDR_DATA, 8'hA5 ^ (8'h33 * i[7:0]));
        end
        rdc(`ADDR_STATUS, 8'h00);
        // Data write in mid-transfer must be masked and flagged
        pload(8'h69);
        fork
            ext_serial_node_i.drive_byte(8);
            begin
                cyc(60);
                wr(`ADDR_DATA, 8'hFF);
                cyc(1);
            end
        join
        cyc(12);
        rdc(`ADDR_STATUS, 8'hC0);
        rdc(`ADDR_DATA, 8'h69);
        rdc(`ADDR_STATUS, 8'h00);
        // Done flag in stop, then request after leaving it
        wr(`ADDR_CONTROL, 8'hC0);
        stop_mode <= 1'b1;
        slave_byte(8'h0F);
        chk({7'h00, irq_req}, 8'h00);
        rdc(`ADDR_STATUS, 8'h80);
        stop_mode <= 1'b0;
        cyc(3);
        chk({7'h00, irq_req}, 8'h01);
        {stop_mode, wait_mode} <= 2'h3;
        cyc(3);
        chk({7'h00, irq_req}, 8'h01);
        {stop_mode, wait_mode} <= 2'h0;
        rdc(`ADDR_DATA, 8'h0F);
        cyc(3);
        chk({7'h00, irq_req}, 8'h00);
        // Master: every rate; receive only at divide-by-16, the pin filter
        // outlasts the faster half periods
        for (int r = 0; r < 4; r++) begin
            wr(`ADDR_CONTROL, 8'h00);
            wr(`ADDR_CONTROL, 8'h50 | {5'h00, (r != 0), r[1:0]});
            pload(8'h96 + r[7:0]);
            wr(`ADDR_DATA, 8'h3A + r[7:0]);
            gap(40);
            gap(40);
            chk(n[7:0], {4'h0, half_t[r]});
            chk({5'h00, port_b_dir}, {6'h01, (r != 0), 1'b0});
            cyc(16 * half_t[r] + 8);
            if (r != 0) chk(p_got, 8'h3A + r[7:0]);
            if (r == 3) begin
                wr(`ADDR_DATA, 8'h11);
                gap(40);
                chk(n[7:0], 8'h28);
            end
            rdc(`ADDR_STATUS, 8'h80);
            rd(`ADDR_DATA);
            if (r == 0) chk(d, 8'h96 + r[7:0]);
        end
        // Stop in mid-byte holds pins, disable then aborts
        wr(`ADDR_CONTROL, 8'h54);
        wr(`ADDR_DATA, 8'hC6);
        cyc(40);
        stop_mode <= 1'b1;
        cyc(3);
        d = {6'h00, sck_out, sdio_out};
        cyc(20);
        chk({6'h00, sck_out, sdio_out}, d);
        stop_mode <= 1'b0;
        cyc(10);
        wr(`ADDR_CONTROL, 8'h00);
        cyc(2);
        chk({6'h00, sck_oe, sdio_oe}, 8'h00);
        // Disabled before stop: nothing may stir
        stop_mode <= 1'b1;
        cyc(200);
        rdc(`ADDR_STATUS, 8'h00);
        chk({7'h00, irq_req}, 8'h00);
        conclude;
    end
endmodule // two_wire_sync_serial_port_bench

bind two_wire_sync_serial_port serial_port_monitor serial_port_monitor_i (
    .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sck_out, .sck_oe, .sdio_out, .sdio_oe, .stop_mode, .wait_mode, .port_b_dir,
    .irq_req);
